// ===== xrr_defines.vh
`ifndef XRR_DEFINES_VH
`define XRR_DEFINES_VH

// On-chip XDATA RAM window F400..FFFF
`define XRR_RAM_BASE 16'hF400
`define XRR_RAM_PAGE_MIN 8'hF3
`define XRR_RAM_WORDS 3072
`define XRR_RAM_AW 12
// Reset values
`define XRR_PAGE_RST 8'h00
`define XRR_PORT_RST 8'hFF
// Move sequencer states
`define XRR_ST_IDLE 2'h0
`define XRR_ST_C1 2'h1
`define XRR_ST_C2 2'h2

`endif

// ===== xrr_rst_sync.v
`timescale 1ns/1ps
// ==========================================
// Reset release synchroniser
module xrr_rst_sync (
    input wire clk_sys, // System clock
    input wire arst_n, // Async reset, active low
    output reg rst_n_sync // Synchronised reset, active low
);
    reg meta_reg;

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= 1'b0;
            rst_n_sync <= 1'b0;
        end else begin
            meta_reg <= 1'b1;
            rst_n_sync <= meta_reg;
        end
    end
endmodule // xrr_rst_sync

// ===== xrr_ram.v
`timescale 1ns/1ps
`include "xrr_defines.vh"
// ==========================================
// On-chip XDATA RAM, no reset on contents
module xrr_ram (
    input wire clk_sys, // System clock
    input wire we, // Write enable
    input wire [11:0] addr, // Word address
    input wire [7:0] wdata, // Write data
    output reg [7:0] rdata // Registered read data
);
    reg [7:0] mem [0:`XRR_RAM_WORDS-1];

    always @(posedge clk_sys) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule // xrr_ram

// ===== xrr_router.v
`timescale 1ns/1ps
`include "xrr_defines.vh"
module xrr_router (
    input wire clk_sys, // System clock 250 MHz
    input wire arst_n, // Async reset, active low
    input wire port_wr, // Write pulse to upper-address port latch
    input wire page_wr, // Write pulse to page register
    input wire [7:0] sfr_wdata, // Data for latch or page write
    input wire ram_dis_clr, // Software write of disable bit = 0
    input wire bus_vis_wr, // Write pulse for visibility bit
    input wire bus_vis_val, // Value for visibility bit
    input wire ext_access_n, // External-access pin level
    input wire mv_start, // Move request pulse
    input wire mv_ptr, // 1 = pointer move, 0 = indirect move
    input wire mv_write, // 1 = write, 0 = read
    input wire [15:0] mv_data_pointer, // Data pointer
    input wire [7:0] mv_index, // Indirect index register
    input wire [7:0] mv_wdata, // Write data
    input wire [7:0] ext_rdata, // Data from external bus
    output reg [7:0] page_q, // Page register contents
    output reg [7:0] port_latch_q, // Upper-address port latch contents
    output reg ram_dis_q, // On-chip RAM disable bit
    output reg bus_vis_q, // Bus visibility bit
    output reg [7:0] up_port_out, // Upper port pin value
    output reg up_port_bus, // Upper port working as address bus
    output reg [7:0] low_port_out, // Low address/data port pin value
    output reg low_port_oe, // Low port driven (open drain otherwise)
    output reg rd_n, // Read strobe, active low
    output reg wr_n, // Write strobe, active low
    output reg mv_internal, // Current move serves on-chip RAM
    output reg mv_done, // Move finished pulse
    output reg [7:0] mv_rdata // Read data to core
);
    wire rst_n;
    reg [1:0] st_reg;
    reg [1:0] st_next;
    reg [15:0] addr_reg;
    reg [7:0] wd_reg;
    reg wr_reg;
    reg ptr_reg;
    reg int_reg;
    reg vis_reg;
    reg ram_we;
    wire [7:0] ram_rdata;
    wire [15:0] ri_addr;
    wire [15:0] eff_addr;
    wire in_range;
    wire go_int;
    wire ram_hit;
    wire [11:0] ram_addr;
    reg fin_reg;
    reg [15:0] addr_next;
    reg [7:0] wd_next;
    reg wr_next;
    reg ptr_next;
    reg int_next;
    reg vis_next;
    reg [7:0] page_next;
    reg [7:0] port_latch_next;
    reg ram_dis_next;
    reg bus_vis_next;
    reg [7:0] up_port_out_next;
    reg up_port_bus_next;
    reg [7:0] low_port_out_next;
    reg low_port_oe_next;
    reg rd_n_next;
    reg wr_n_next;
    reg mv_internal_next;
    reg mv_done_next;
    reg [7:0] mv_rdata_next;

    xrr_rst_sync u_rst (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .rst_n_sync(rst_n)
    );

    // ==========================================
    // Address decode
    // page plus index
    assign ri_addr = {page_q, mv_index};
    assign eff_addr = mv_ptr ? mv_data_pointer : ri_addr;
    assign in_range = (eff_addr >= `XRR_RAM_BASE) && (mv_ptr || page_q >= `XRR_RAM_PAGE_MIN);
    assign go_int = in_range && !ram_dis_q;
    assign ram_hit = st_reg != `XRR_ST_IDLE ? int_reg : 1'b0;
    assign ram_addr = addr_reg[11:0] - 12'h400;

    // ==========================================
    // Control register next values
    always @* begin
        page_next = page_q;
        port_latch_next = port_latch_q;
        ram_dis_next = ram_dis_q;
        bus_vis_next = bus_vis_q;
        if (port_wr) begin
            port_latch_next = sfr_wdata;
            page_next = sfr_wdata;
        end else if (page_wr) begin
            page_next = sfr_wdata;
        end
        if (ram_dis_clr) begin
            ram_dis_next = 1'b0;
        end
        if (bus_vis_wr) begin
            bus_vis_next = bus_vis_val;
        end
    end

    // ==========================================
    // Control registers
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            page_q <= `XRR_PAGE_RST;
            port_latch_q <= `XRR_PORT_RST;
            ram_dis_q <= 1'b1;
            bus_vis_q <= 1'b0;
        end else begin
            page_q <= page_next;
            port_latch_q <= port_latch_next;
            ram_dis_q <= ram_dis_next;
            bus_vis_q <= bus_vis_next;
        end
    end

    // ==========================================
    // Move sequencer: two cycles per move
    always @* begin
        st_next = st_reg;
        case (st_reg)
            `XRR_ST_IDLE: begin
                if (mv_start) begin
                    st_next = `XRR_ST_C1;
                end
            end
            `XRR_ST_C1: st_next = `XRR_ST_C2;
            `XRR_ST_C2: st_next = `XRR_ST_IDLE;
            default: st_next = `XRR_ST_IDLE;
        endcase
    end

    // ==========================================
    // Move capture next values
    always @* begin
        addr_next = addr_reg;
        wd_next = wd_reg;
        wr_next = wr_reg;
        ptr_next = ptr_reg;
        int_next = int_reg;
        vis_next = vis_reg;
        if (st_reg == `XRR_ST_IDLE && mv_start) begin
            // external indirect uses port latch as upper byte
            addr_next = (mv_ptr || go_int) ? eff_addr : {port_latch_q, mv_index};
            wd_next = mv_wdata;
            wr_next = mv_write;
            ptr_next = mv_ptr;
            int_next = go_int;
            // bus shows internal access in pin-low or visible mode
            vis_next = bus_vis_q || !ext_access_n;
        end
    end

    // ==========================================
    // Move registers
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= `XRR_ST_IDLE;
            addr_reg <= 16'h0000;
            wd_reg <= 8'h00;
            wr_reg <= 1'b0;
            ptr_reg <= 1'b0;
            int_reg <= 1'b0;
            vis_reg <= 1'b0;
            fin_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            addr_reg <= addr_next;
            wd_reg <= wd_next;
            wr_reg <= wr_next;
            ptr_reg <= ptr_next;
            int_reg <= int_next;
            vis_reg <= vis_next;
            // Read data is returned one cycle after the strobe goes out
            fin_reg <= (st_reg == `XRR_ST_C2);
        end
    end

    // ==========================================
    // RAM write commit at the end of cycle one
    // reset in cycle one drops the write
    // Once cycle one has ended the location already holds the new value
    always @* begin
        ram_we = (st_reg == `XRR_ST_C1) && ram_hit && wr_reg;
    end

    xrr_ram u_ram (
        .clk_sys(clk_sys),
        .we(ram_we),
        .addr(ram_addr),
        .wdata(wd_reg),
        .rdata(ram_rdata)
    );

    // ==========================================
    // Pin and strobe next values
    always @* begin
        up_port_out_next = port_latch_q;
        up_port_bus_next = 1'b0;
        low_port_out_next = 8'h00;
        low_port_oe_next = 1'b0;
        rd_n_next = 1'b1;
        wr_n_next = 1'b1;
        mv_internal_next = ram_hit;
        mv_done_next = 1'b0;
        mv_rdata_next = mv_rdata;
        if (st_reg == `XRR_ST_C1) begin
            // external moves, or visible internal moves
            if (!int_reg || vis_reg) begin
                low_port_oe_next = 1'b1;
                low_port_out_next = addr_reg[7:0];
                // indirect keeps upper port as I/O
                if (ptr_reg) begin
                    up_port_bus_next = 1'b1;
                    up_port_out_next = addr_reg[15:8];
                end
            end
        end else if (st_reg == `XRR_ST_C2) begin
            if (!int_reg || vis_reg) begin
                // visible internal move shows read or write data
                low_port_oe_next = wr_reg || int_reg;
                if (wr_reg) begin
                    low_port_out_next = wd_reg;
                end else if (int_reg) begin
                    low_port_out_next = ram_rdata;
                end
                if (ptr_reg) begin
                    up_port_bus_next = 1'b1;
                    up_port_out_next = addr_reg[15:8];
                end
                // strobes on external or visibility bit set; none
                if (!int_reg || bus_vis_q) begin
                    rd_n_next = wr_reg;
                    wr_n_next = !wr_reg;
                end
            end
        end
        // External read data is taken while the read strobe is low
        if (fin_reg) begin
            mv_done_next = 1'b1;
            mv_rdata_next = int_reg ? ram_rdata : ext_rdata;
        end
    end

    // ==========================================
    // Pin and strobe registers
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            up_port_out <= `XRR_PORT_RST;
            up_port_bus <= 1'b0;
            low_port_out <= 8'h00;
            low_port_oe <= 1'b0;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            mv_internal <= 1'b0;
            mv_done <= 1'b0;
            mv_rdata <= 8'h00;
        end else begin
            up_port_out <= up_port_out_next;
            up_port_bus <= up_port_bus_next;
            low_port_out <= low_port_out_next;
            low_port_oe <= low_port_oe_next;
            rd_n <= rd_n_next;
            wr_n <= wr_n_next;
            mv_internal <= mv_internal_next;
            mv_done <= mv_done_next;
            mv_rdata <= mv_rdata_next;
        end
    end
endmodule // xrr_router

// ===== xrr_router_checker.sv
`timescale 1ns/1ps
// ==========================================
// Port checker for the access router
module xrr_router_checker (
    input wire clk_sys, // clock
    input wire arst_n, // reset
    input wire port_wr, // latch write
    input wire page_wr, // page write
    input wire [7:0] sfr_wdata, // data
    input wire mv_start, // start
    input wire mv_ptr, // pointer move
    input wire [15:0] mv_data_pointer, // pointer
    input wire ext_access_n, // pin
    input wire [7:0] page_q, // page
    input wire [7:0] port_latch_q, // latch
    input wire ram_dis_q, // disable
    input wire bus_vis_q, // visible
    input wire up_port_bus, // upper bus
    input wire low_port_oe, // low drive
    input wire rd_n, // read strobe
    input wire wr_n, // write strobe
    input wire [7:0] up_port_out, // upper port value
    input wire [7:0] low_port_out, // low port value
    input wire mv_internal // move served on chip
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    sequence s_strobe;
        !rd_n || !wr_n;
    endsequence
    sequence s_quiet;
        rd_n && wr_n && !low_port_oe && !up_port_bus;
    endsequence
    wire ptr_ram = mv_start && mv_ptr && !ram_dis_q && mv_data_pointer >= 16'hF400;
    a_ram_dis_sticky: assert property (!ram_dis_q |=> !ram_dis_q)
        else $error("disable bit set again");
    a_port_loads_page: assert property (port_wr |=> page_q == $past(sfr_wdata))
        else $error("page not loaded by latch write");
    a_page_only: assert property (page_wr && !port_wr |=>
        page_q == $past(sfr_wdata) && port_latch_q == $past(port_latch_q))
        else $error("page write wrong");
    a_dis_goes_ext: assert property (mv_start && ram_dis_q |-> ##[2:3] s_strobe)
        else $error("no strobe while disabled");
    a_low_ptr_ext: assert property (mv_start && mv_ptr && mv_data_pointer < 16'hF400
        |-> ##[2:3] s_strobe) else $error("low pointer move not external");
    a_low_page_ext: assert property (mv_start && !mv_ptr && page_q < 8'hF3
        |-> ##[2:3] s_strobe) else $error("low page move not external");
    a_indirect_up_io: assert property (mv_start && !mv_ptr |=> !up_port_bus [*3])
        else $error("upper port left I/O");
    a_internal_quiet: assert property (ptr_ram && !bus_vis_q |=> (rd_n && wr_n) [*3])
        else $error("strobe on hidden internal move");
    a_pin_high_io: assert property (ptr_ram && !bus_vis_q && ext_access_n
        |=> s_quiet [*3]) else $error("ports not I/O");
    a_visible_strobe: assert property (ptr_ram && bus_vis_q |-> ##[2:3] s_strobe)
        else $error("no strobe on visible move");
    a_ram_serves: assert property (ptr_ram |-> ##2 mv_internal)
        else $error("on-chip range move not internal");
    a_bus_shows_addr: assert property (ptr_ram && (bus_vis_q || !ext_access_n)
        |-> ##2 low_port_oe && up_port_bus && {up_port_out, low_port_out} == $past(mv_data_pointer, 2))
        else $error("internal move address not on bus");
endmodule // xrr_router_checker
bind xrr_router xrr_router_checker u_chk (.*);

// ===== xrr_ext_mem.sv
`timescale 1ns/1ps
// ==========================================
// External data memory on the multiplexed bus
module xrr_ext_mem (
    input wire clk_sys, // clock
    input wire [7:0] low_port_out, // bus value
    input wire low_port_oe, // bus driven
    input wire rd_n, // read strobe
    input wire wr_n, // write strobe
    output wire [7:0] ext_rdata // read data
);
    reg [7:0] mem [0:255];
    reg [7:0] addr_reg = 8'h00;
    reg [7:0] last_reg = 8'h00;
    // Released bus toggles so stale data never looks valid
    assign ext_rdata = rd_n ? ~last_reg : mem[addr_reg];
    always @(posedge clk_sys) begin
        last_reg <= ext_rdata;
        if (low_port_oe && rd_n && wr_n)
            addr_reg <= low_port_out;
        if (!wr_n)
            mem[addr_reg] <= low_port_out;
    end
endmodule // xrr_ext_mem

// ===== xrr_router_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %s exp %h got %h", n, e, g); end end
// ==========================================
// Router bench
module xrr_router_tb;
    reg clk_sys = 1'h0, arst_n = 1'h0, port_wr = 1'h0, page_wr = 1'h0, ram_dis_clr = 1'h0;
    reg bus_vis_wr = 1'h0, bus_vis_val = 1'h0, ext_access_n = 1'h1, mv_start = 1'h0;
    reg mv_ptr = 1'h0, mv_write = 1'h0;
    reg [15:0] mv_data_pointer = 16'h0000;
    reg [7:0] mv_index = 8'h00, mv_wdata = 8'h00, sfr_wdata = 8'h00;
    wire [7:0] ext_rdata, page_q, port_latch_q, up_port_out, low_port_out, mv_rdata;
    wire ram_dis_q, bus_vis_q, up_port_bus, low_port_oe, rd_n, wr_n, mv_internal, mv_done;
    int fails = 0;
    int total_checks = 0;
    xrr_router uut (.*);
    xrr_ext_mem u_mem (.*);
    always #2 clk_sys = ~clk_sys;
    task summarize;
        if (fails == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task rst;
        arst_n <= 1'h0;
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'h1;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    // Control write: 0 latch, 1 page, 2 clear disable, 3 visibility
    task sw(input int k, input logic [7:0] d);
        @(posedge clk_sys);
        {port_wr, page_wr, ram_dis_clr, bus_vis_wr} <= 4'h8 >> k;
        sfr_wdata <= d;
        bus_vis_val <= d[0];
        @(posedge clk_sys);
        {port_wr, page_wr, ram_dis_clr, bus_vis_wr} <= 4'h0;
        @(posedge clk_sys);
        #1;
    endtask
    task mv(input logic p, w, input logic [15:0] a, input logic [7:0] d, input int c);
        int n;
        n = 0;
        @(posedge clk_sys);
        mv_start <= 1'h1;
        {mv_ptr, mv_write, mv_data_pointer, mv_index, mv_wdata} <= {p, w, a, a[7:0], d};
        @(posedge clk_sys);
        mv_start <= 1'h0;
        if (c > 0) begin
            // Reset lands in move cycle c
            repeat (c - 1) @(posedge clk_sys);
            rst;
        end else begin
            #1;
            while (mv_done !== 1'h1 && n < 8) begin
                @(posedge clk_sys);
                #1;
                n++;
            end
            if (mv_done !== 1'h1) begin
                fails++;
                summarize;
            end
            if (!w) `CHK("read data", d, mv_rdata)
        end
    endtask
    initial begin
        rst;
        `CHK("page", 8'h00, page_q)
        `CHK("disable", 1'h1, ram_dis_q)
        sw(0, 8'hAA);
        `CHK("page", 8'hAA, page_q)
        sw(1, 8'hF8);
        `CHK("latch", 8'hAA, port_latch_q)
        mv(1, 1, 16'hF830, 8'h5C, 0);
        mv(1, 0, 16'hF830, 8'h5C, 0);
        sw(2, 8'h00);
        sw(3, 8'h00);
        `CHK("disable", 1'h0, ram_dis_q)
        mv(1, 1, 16'hF830, 8'h3C, 0);
        mv(1, 0, 16'hF830, 8'h3C, 0);
        mv(0, 0, 16'h0030, 8'h3C, 0);
        sw(0, 8'h12);
        mv(0, 0, 16'h0030, 8'h5C, 0);
        `CHK("upper port", 8'h12, up_port_out)
        sw(1, 8'hF8);
        mv(1, 1, 16'h1030, 8'h77, 0);
        mv(1, 0, 16'h1030, 8'h77, 0);
        ext_access_n <= 1'h0;
        mv(1, 0, 16'hF830, 8'h3C, 0);
        sw(3, 8'h01);
        mv(1, 0, 16'hF830, 8'h3C, 0);
        mv(1, 1, 16'hF830, 8'h11, 1);
        sw(2, 8'h00);
        mv(1, 0, 16'hF830, 8'h3C, 0);
        mv(1, 1, 16'hF830, 8'h22, 2);
        sw(2, 8'h00);
        mv(1, 0, 16'hF830, 8'h22, 0);
        summarize;
    end
endmodule // xrr_router_tb
